/* File: pio_panel.sv */
// Front-panel function logic: error history, jog, output forcing and I/O diagnosis
// Contract
// - Selected history slot plus confirm key shows that slot's stored fault code.
// - Confirm on jog parameter shows jog speed, defaulting to 20 r/min.
// - Up and down keys change jog speed while it is shown.
// - Confirm after adjusting speed enters jog mode and shows jog indication.
// - In jog mode held up/down turns motor one direction; release stops.
// - Jog keys move the motor only while the servo is enabled.
// - Writing 006 to force control makes outputs follow the force mask.
// - Force mask bit n drives output n+1 in forced mode.
// - Forcing is cleared at power-up or by writing 106.
// - Force mask shown in hex, fifth digit zero suppressed.
// - Input diagnosis shows nine inputs as hex image, bit0 is input 1.
// - Output diagnosis shows six outputs as hex image, bit0 is output 1.
// - Input image is formed from the external input lines as driven.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
module pio_panel (
   // Clock and reset
   input  wire logic                                clk_in,
   input  wire logic                                rst_n_in,
   // AXI4-Lite write address and data
   input  wire logic [7:0]                          s_axi_awaddr_in,
   input  wire logic                                s_axi_awvalid_in,
   output logic                                     s_axi_awready_out,
   input  wire logic [31:0]                         s_axi_wdata_in,
   input  wire logic [3:0]                          s_axi_wstrb_in,
   input  wire logic                                s_axi_wvalid_in,
   output logic                                     s_axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0]                               s_axi_bresp_out,
   output logic                                     s_axi_bvalid_out,
   input  wire logic                                s_axi_bready_in,
   // AXI4-Lite read
   input  wire logic [7:0]                          s_axi_araddr_in,
   input  wire logic                                s_axi_arvalid_in,
   output logic                                     s_axi_arready_out,
   output logic [31:0]                              s_axi_rdata_out,
   output logic [1:0]                               s_axi_rresp_out,
   output logic                                     s_axi_rvalid_out,
   input  wire logic                                s_axi_rready_in,
   // Operator keys and display
   input  wire pio_pkg::pio_key_s                   keys_in,
   output pio_pkg::pio_disp_s                       display_out,
   // Drive core
   input  wire logic                                servo_on_in,
   input  wire logic                                fault_valid_in,
   input  wire logic [pio_pkg::PIO_CODE_W-1:0]      fault_code_in,
   output pio_pkg::pio_motor_s                      motor_out,
   // Digital I/O lines
   input  wire logic [pio_pkg::PIO_NUM_DI-1:0]      input_line_in,
   input  wire logic [pio_pkg::PIO_NUM_DO-1:0]      output_normal_in,
   output logic [pio_pkg::PIO_NUM_DO-1:0]           output_line_out,
   // Interrupt
   output logic                                     irq_out
);

   // Software-visible state
   logic [5:0]                         ctrl_reg;
   logic                               forced_reg;
   logic [pio_pkg::PIO_NUM_DO-1:0]     mask_reg;
   logic [pio_pkg::PIO_IRQ_W-1:0]      irq_stat_reg;
   logic [pio_pkg::PIO_IRQ_W-1:0]      irq_stat_next;
   logic [pio_pkg::PIO_IRQ_W-1:0]      irq_mask_reg;

   // Panel state
   pio_pkg::pio_state_e                state_reg;
   pio_pkg::pio_state_e                state_next;
   logic [15:0]                        speed_reg;
   logic [15:0]                        speed_next;
   logic [pio_pkg::PIO_NUM_DI-1:0]     di_reg;
   logic [pio_pkg::PIO_NUM_DO-1:0]     do_reg;
   logic [pio_pkg::PIO_NUM_DO-1:0]     do_next;
   pio_pkg::pio_motor_s                motor_reg;
   pio_pkg::pio_motor_s                motor_next;
   pio_pkg::pio_disp_s                 disp_reg;
   pio_pkg::pio_disp_s                 disp_next;

   // Bus state
   logic                               aw_hold_reg;
   logic [7:0]                         awaddr_reg;
   logic                               w_hold_reg;
   logic [31:0]                        wdata_reg;
   logic [3:0]                         wstrb_reg;
   logic                               bvalid_reg;
   logic [1:0]                         bresp_reg;
   logic                               rvalid_reg;
   logic [31:0]                        rdata_reg;
   logic [1:0]                         rresp_reg;

   // Key pulses and history read
   pio_pkg::pio_key_s                  press;
   logic [pio_pkg::PIO_CODE_W-1:0]     hist_code;

   pio_keys u_keys (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .keys_in   (keys_in),
      .press_out (press)
   );

   pio_hist u_hist (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .fault_valid_in (fault_valid_in),
      .fault_code_in  (fault_code_in),
      .slot_in        (ctrl_reg[pio_pkg::PIO_SLOT_MSB:pio_pkg::PIO_SLOT_LSB]),
      .code_out       (hist_code)
   );

   // Decode of the selected function
   logic [2:0] sel;
   assign sel = ctrl_reg[pio_pkg::PIO_SEL_MSB:pio_pkg::PIO_SEL_LSB];

   // Readback mux shared by reads and byte-lane merging on writes
   function automatic logic [32:0] rd_mux(input logic [7:0] a);
      logic [31:0] v;
      logic        hit;
      v   = '0;
      hit = 1'b1;
      unique case (a)
         pio_pkg::PIO_CTRL_OFS:       v = {26'h0, ctrl_reg};
         pio_pkg::PIO_FORCE_CTRL_OFS: v = forced_reg ? {20'h0, pio_pkg::PIO_FORCE_ON}
                                                     : {20'h0, pio_pkg::PIO_FORCE_OFF};
         pio_pkg::PIO_FORCE_MASK_OFS: v = {26'h0, mask_reg};
         pio_pkg::PIO_STATUS_OFS:     v = {24'h0, motor_reg.ccw, motor_reg.run,
                                           servo_on_in, forced_reg, 1'b0, state_reg};
         pio_pkg::PIO_JOG_SPEED_OFS:  v = {16'h0, speed_reg};
         pio_pkg::PIO_IRQ_STAT_OFS:   v = {27'h0, irq_stat_reg};
         pio_pkg::PIO_IRQ_MASK_OFS:   v = {27'h0, irq_mask_reg};
         pio_pkg::PIO_DISPLAY_OFS:    v = {6'h0, disp_reg};
         default:                     hit = 1'b0;
      endcase
      return {hit, v};
   endfunction

   // Write channel: address and data taken in either order
   logic        aw_fire;
   logic        w_fire;
   logic        wr_do;
   logic [32:0] wr_cur;
   logic [31:0] wr_lane;
   logic [31:0] wr_val;
   logic        wr_hit;

   assign s_axi_awready_out = ~aw_hold_reg & ~bvalid_reg;
   assign s_axi_wready_out  = ~w_hold_reg & ~bvalid_reg;
   assign aw_fire = s_axi_awvalid_in & s_axi_awready_out;
   assign w_fire  = s_axi_wvalid_in & s_axi_wready_out;
   assign wr_do   = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   always_comb wr_cur = rd_mux(awaddr_reg);
   assign wr_hit  = wr_cur[32];
   assign wr_lane = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign wr_val  = (wr_cur[31:0] & ~wr_lane) | (wdata_reg & wr_lane);

   logic wr_ctrl;
   logic wr_fctl;
   logic wr_mask;
   logic wr_imsk;
   assign wr_ctrl = wr_do & (awaddr_reg == pio_pkg::PIO_CTRL_OFS);
   assign wr_fctl = wr_do & (awaddr_reg == pio_pkg::PIO_FORCE_CTRL_OFS);
   assign wr_mask = wr_do & (awaddr_reg == pio_pkg::PIO_FORCE_MASK_OFS);
   assign wr_imsk = wr_do & (awaddr_reg == pio_pkg::PIO_IRQ_MASK_OFS);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg  <= '0;
         w_hold_reg  <= 1'b0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= pio_pkg::PIO_RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr_in;
         end
         if (w_fire) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_in;
            wstrb_reg  <= s_axi_wstrb_in;
         end
         if (wr_do) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_hit ? pio_pkg::PIO_RESP_OKAY : pio_pkg::PIO_RESP_SLVERR;
         end else if (bvalid_reg & s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid_out = bvalid_reg;
   assign s_axi_bresp_out  = bresp_reg;

   // Read channel
   logic        ar_fire;
   logic [32:0] rd_val;
   logic        rd_clr;

   assign s_axi_arready_out = ~rvalid_reg;
   assign ar_fire = s_axi_arvalid_in & s_axi_arready_out;
   always_comb rd_val = rd_mux(s_axi_araddr_in);
   assign rd_clr  = ar_fire & (s_axi_araddr_in == pio_pkg::PIO_IRQ_STAT_OFS);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= pio_pkg::PIO_RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_val[31:0];
         rresp_reg  <= rd_val[32] ? pio_pkg::PIO_RESP_OKAY : pio_pkg::PIO_RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready_in) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid_out = rvalid_reg;
   assign s_axi_rdata_out  = rdata_reg;
   assign s_axi_rresp_out  = rresp_reg;

   // Force control: only the two documented codes act, anything else leaves forcing as is
   logic force_on_wr;
   logic force_off_wr;
   assign force_on_wr  = wr_fctl & (wr_val[11:0] == pio_pkg::PIO_FORCE_ON);
   assign force_off_wr = wr_fctl & (wr_val[11:0] == pio_pkg::PIO_FORCE_OFF);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_reg     <= '0;
         forced_reg   <= 1'b0;
         mask_reg     <= '0;
         irq_mask_reg <= pio_pkg::PIO_MASK_RST;
      end else begin
         if (wr_ctrl) ctrl_reg <= wr_val[5:0];
         if (force_on_wr) forced_reg <= 1'b1;
         else if (force_off_wr) forced_reg <= 1'b0;
         if (wr_mask) mask_reg <= wr_val[pio_pkg::PIO_NUM_DO-1:0];
         if (wr_imsk) irq_mask_reg <= wr_val[pio_pkg::PIO_IRQ_W-1:0];
      end
   end

   // Panel key state machine
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pio_pkg::PIO_ST_IDLE: begin
            if (press.set) begin
               unique case (sel)
                  pio_pkg::PIO_SEL_HIST: state_next = pio_pkg::PIO_ST_HIST;
                  pio_pkg::PIO_SEL_JOG:  state_next = pio_pkg::PIO_ST_SPEED;
                  pio_pkg::PIO_SEL_MASK: state_next = pio_pkg::PIO_ST_MASK;
                  pio_pkg::PIO_SEL_INDG: state_next = pio_pkg::PIO_ST_INDG;
                  pio_pkg::PIO_SEL_OUTD: state_next = pio_pkg::PIO_ST_OUTD;
                  default:               state_next = pio_pkg::PIO_ST_IDLE;
               endcase
            end
         end
         pio_pkg::PIO_ST_SPEED: begin
            if (press.mode) state_next = pio_pkg::PIO_ST_IDLE;
            else if (press.set) state_next = pio_pkg::PIO_ST_JOG;
         end
         pio_pkg::PIO_ST_JOG,
         pio_pkg::PIO_ST_HIST,
         pio_pkg::PIO_ST_MASK,
         pio_pkg::PIO_ST_INDG,
         pio_pkg::PIO_ST_OUTD: begin
            if (press.mode) state_next = pio_pkg::PIO_ST_IDLE;
         end
         default: state_next = pio_pkg::PIO_ST_IDLE;
      endcase
   end

   // Jog speed edit, saturating at the limits
   logic in_speed;
   assign in_speed = (state_reg == pio_pkg::PIO_ST_SPEED);

   always_comb begin
      speed_next = speed_reg;
      if (in_speed & press.up & ~press.down & (speed_reg < pio_pkg::PIO_JOG_MAX))
         speed_next = speed_reg + pio_pkg::PIO_JOG_STEP;
      else if (in_speed & press.down & ~press.up & (speed_reg > pio_pkg::PIO_JOG_MIN))
         speed_next = speed_reg - pio_pkg::PIO_JOG_STEP;
   end

   // Motor command: both keys together count as neither, to avoid a direction fight
   logic in_jog;
   logic jog_key;
   assign in_jog  = (state_reg == pio_pkg::PIO_ST_JOG);
   assign jog_key = keys_in.up ^ keys_in.down;

   always_comb begin
      motor_next.run   = in_jog & jog_key & servo_on_in;
      motor_next.ccw   = keys_in.down;
      motor_next.speed = speed_reg;
   end

   // Digital outputs: mask bit n drives output line n+1
   assign do_next = forced_reg ? mask_reg : output_normal_in;

   // Display composition, redrawn every cycle
   always_comb begin
      disp_next = '0;
      unique case (state_reg)
         pio_pkg::PIO_ST_HIST: begin
            disp_next.value = {8'h00, hist_code};
            disp_next.blank = 5'h18;
         end
         pio_pkg::PIO_ST_SPEED: begin
            disp_next.value = {4'h0, speed_reg};
         end
         pio_pkg::PIO_ST_JOG: begin
            disp_next.jog_text = 1'b1;
         end
         pio_pkg::PIO_ST_MASK: begin
            disp_next.value = {14'h0000, mask_reg};
            disp_next.blank = {(disp_next.value[19:16] == 4'h0), 4'h0};
         end
         pio_pkg::PIO_ST_INDG: begin
            disp_next.value = {11'h000, di_reg};
         end
         pio_pkg::PIO_ST_OUTD: begin
            disp_next.value = {14'h0000, do_reg};
         end
         default: begin
            disp_next.value = {17'h00000, sel};
         end
      endcase
   end

   // Interrupt events; a set in the clearing cycle survives the clear
   logic [pio_pkg::PIO_IRQ_W-1:0] irq_evt;
   logic                          jog_enter;
   assign jog_enter = (state_next == pio_pkg::PIO_ST_JOG) & ~in_jog;

   always_comb begin
      irq_evt = '0;
      irq_evt[pio_pkg::PIO_IRQ_FAULT] = fault_valid_in;
      irq_evt[pio_pkg::PIO_IRQ_JOG]   = jog_enter;
      irq_evt[pio_pkg::PIO_IRQ_FORCE] = (force_on_wr & ~forced_reg) | (force_off_wr & forced_reg);
      irq_evt[pio_pkg::PIO_IRQ_DI]    = (input_line_in != di_reg);
      irq_evt[pio_pkg::PIO_IRQ_NOSRV] = in_jog & jog_key & ~servo_on_in;
      irq_stat_next = (rd_clr ? '0 : irq_stat_reg) | irq_evt;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg    <= pio_pkg::PIO_ST_IDLE;
         speed_reg    <= pio_pkg::PIO_JOG_DEF;
         di_reg       <= '0;
         do_reg       <= '0;
         motor_reg    <= '0;
         disp_reg     <= '0;
         irq_stat_reg <= pio_pkg::PIO_IRQ_RST;
      end else begin
         state_reg    <= state_next;
         speed_reg    <= speed_next;
         di_reg       <= input_line_in;
         do_reg       <= do_next;
         motor_reg    <= motor_next;
         disp_reg     <= disp_next;
         irq_stat_reg <= irq_stat_next;
      end
   end

   assign output_line_out = do_reg;
   assign motor_out       = motor_reg;
   assign display_out     = disp_reg;
   assign irq_out         = |(irq_stat_reg & irq_mask_reg);

endmodule // pio_panel

/* File: pio_pkg.sv */
// Package with register map, field layout, constants and carrier types of the panel I/O block
package pio_pkg;

   // Register byte offsets
   localparam logic [7:0] PIO_CTRL_OFS       = 8'h00;
   localparam logic [7:0] PIO_FORCE_CTRL_OFS = 8'h04;
   localparam logic [7:0] PIO_FORCE_MASK_OFS = 8'h08;
   localparam logic [7:0] PIO_STATUS_OFS     = 8'h0c;
   localparam logic [7:0] PIO_JOG_SPEED_OFS  = 8'h10;
   localparam logic [7:0] PIO_IRQ_STAT_OFS   = 8'h14;
   localparam logic [7:0] PIO_IRQ_MASK_OFS   = 8'h18;
   localparam logic [7:0] PIO_DISPLAY_OFS    = 8'h1c;

   // Control register fields
   localparam int PIO_SEL_LSB  = 0;
   localparam int PIO_SEL_MSB  = 2;
   localparam int PIO_SLOT_LSB = 3;
   localparam int PIO_SLOT_MSB = 5;

   // Parameter selection codes
   localparam logic [2:0] PIO_SEL_NONE = 3'h0;
   localparam logic [2:0] PIO_SEL_HIST = 3'h1;
   localparam logic [2:0] PIO_SEL_JOG  = 3'h2;
   localparam logic [2:0] PIO_SEL_MASK = 3'h3;
   localparam logic [2:0] PIO_SEL_INDG = 3'h4;
   localparam logic [2:0] PIO_SEL_OUTD = 3'h5;

   // Output force control codes
   localparam logic [11:0] PIO_FORCE_ON  = 12'h006;
   localparam logic [11:0] PIO_FORCE_OFF = 12'h106;

   // Sizes and limits
   localparam int          PIO_NUM_DI    = 9;
   localparam int          PIO_NUM_DO    = 6;
   localparam int          PIO_HIST_N    = 5;
   localparam int          PIO_CODE_W    = 12;
   localparam logic [15:0] PIO_JOG_DEF   = 16'h0014;
   localparam logic [15:0] PIO_JOG_MIN   = 16'h0000;
   localparam logic [15:0] PIO_JOG_MAX   = 16'h1388;
   localparam logic [15:0] PIO_JOG_STEP  = 16'h0001;
   localparam logic [4:0]  PIO_IRQ_RST   = 5'h00;
   localparam logic [4:0]  PIO_MASK_RST  = 5'h00;

   // Interrupt bits
   localparam int PIO_IRQ_FAULT = 0;
   localparam int PIO_IRQ_JOG   = 1;
   localparam int PIO_IRQ_FORCE = 2;
   localparam int PIO_IRQ_DI    = 3;
   localparam int PIO_IRQ_NOSRV = 4;
   localparam int PIO_IRQ_W     = 5;

   // AXI responses
   localparam logic [1:0] PIO_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      PIO_ST_IDLE  = 3'h0,
      PIO_ST_SPEED = 3'h1,
      PIO_ST_JOG   = 3'h3,
      PIO_ST_HIST  = 3'h2,
      PIO_ST_MASK  = 3'h6,
      PIO_ST_INDG  = 3'h7,
      PIO_ST_OUTD  = 3'h5
   } pio_state_e;

   typedef struct packed {
      logic set;
      logic up;
      logic down;
      logic mode;
   } pio_key_s;

   typedef struct packed {
      logic [19:0] value;
      logic [4:0]  blank;
      logic        jog_text;
   } pio_disp_s;

   typedef struct packed {
      logic        run;
      logic        ccw;
      logic [15:0] speed;
   } pio_motor_s;

endpackage

/* File: pio_keys.sv */
// Key press edge detector producing one-cycle pulses per panel key
module pio_keys (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   // Key levels and press pulses
   input  wire pio_pkg::pio_key_s keys_in,
   output pio_pkg::pio_key_s      press_out
);

   logic [3:0] prev_reg;
   logic [3:0] lvl;
   logic [3:0] prs;

   assign lvl = keys_in;

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_key
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) prev_reg[i] <= 1'b0;
            else prev_reg[i] <= lvl[i];
         end
         assign prs[i] = lvl[i] & ~prev_reg[i];
      end
   endgenerate

   assign press_out = prs;

endmodule // pio_keys

/* File: pio_hist.sv */
// Error history store: newest fault code in slot 0, older ones shift up
module pio_hist (
   // Clock and reset
   input  wire logic                            clk_in,
   input  wire logic                            rst_n_in,
   // Fault capture
   input  wire logic                            fault_valid_in,
   input  wire logic [pio_pkg::PIO_CODE_W-1:0]  fault_code_in,
   // Slot read
   input  wire logic [2:0]                      slot_in,
   output logic      [pio_pkg::PIO_CODE_W-1:0]  code_out
);

   logic [pio_pkg::PIO_CODE_W-1:0] slot_reg [pio_pkg::PIO_HIST_N];

   genvar i;
   generate
      for (i = 0; i < pio_pkg::PIO_HIST_N; i++) begin : g_slot
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) slot_reg[i] <= '0;
            else if (fault_valid_in)
               slot_reg[i] <= (i == 0) ? fault_code_in : slot_reg[(i == 0) ? 0 : i - 1];
         end
      end
   endgenerate

   // Out-of-range slots read as zero instead of aliasing
   assign code_out = (slot_in < 3'(pio_pkg::PIO_HIST_N)) ? slot_reg[slot_in] : '0;

endmodule // pio_hist

/* File: pio_far.sv */
// Model of the operator keypad and the external I/O lines
module pio_far (
   // Clock
   input  wire logic         clk_in,
   // Keys and lines toward the block
   output pio_pkg::pio_key_s keys_out,
   output logic [8:0]        input_line_out,
   output logic [5:0]        output_normal_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      keys_out = '0;
      input_line_out = '0;
      output_normal_out = '0;
   end
   // Always released afterwards, so the next press is a fresh edge
   task automatic hold(input pio_pkg::pio_key_s k, input int n);
      @(posedge clk_in);
      keys_out <= k;
      repeat (n) @(posedge clk_in);
      keys_out <= '0;
      repeat (3) @(posedge clk_in);
   endtask
   task automatic lines(input logic [8:0] i, input logic [5:0] o);
      @(posedge clk_in);
      input_line_out <= i;
      output_normal_out <= o;
   endtask
endmodule // pio_far

/* File: pio_chk.sv */
// Port checker of the panel I/O block
module pio_chk (
   // Clock and reset
   input wire logic                clk_in,
   input wire logic                rst_n_in,
   // Watched ports
   input wire logic                s_axi_awready_out,
   input wire logic                s_axi_wready_out,
   input wire logic [1:0]          s_axi_bresp_out,
   input wire logic                s_axi_bvalid_out,
   input wire logic                s_axi_bready_in,
   input wire logic [31:0]         s_axi_rdata_out,
   input wire logic                s_axi_rvalid_out,
   input wire logic                s_axi_rready_in,
   input wire pio_pkg::pio_key_s   keys_in,
   input wire pio_pkg::pio_disp_s  display_out,
   input wire logic                servo_on_in,
   input wire pio_pkg::pio_motor_s motor_out,
   input wire logic [5:0]          output_normal_in,
   input wire logic [5:0]          output_line_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   key_release_a: assert property (!keys_in.up && !keys_in.down |=> !motor_out.run)
      else $error("motor runs with no jog key");
   servo_off_a: assert property (!servo_on_in |=> !motor_out.run)
      else $error("motor runs with servo off");
   jog_dir_a: assert property (motor_out.run |-> motor_out.ccw == $past(keys_in.down))
      else $error("jog direction wrong");
   one_key_a: assert property (motor_out.run |-> $past(keys_in.up) != $past(keys_in.down))
      else $error("motor runs without exactly one key");
   jog_shown_a: assert property (motor_out.run |-> display_out.jog_text)
      else $error("motor runs outside jog display");
   power_up_a: assert property ($rose(rst_n_in) |=> output_line_out == $past(output_normal_in))
      else $error("outputs not normal after reset");
   b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
   w_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken during response");
endmodule // pio_chk
bind pio_panel pio_chk u_chk (.clk_in, .rst_n_in, .s_axi_awready_out, .s_axi_wready_out,
   .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_rdata_out, .s_axi_rvalid_out,
   .s_axi_rready_in, .keys_in, .display_out, .servo_on_in, .motor_out, .output_normal_in,
   .output_line_out);

/* File: tb_top.sv */
// Self-checking testbench of the panel I/O block
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pio_pkg::*;
   logic              clk_in = 0, rst_n_in = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic              arvalid = 0, rready = 0, servo = 0, fvalid = 0;
   logic              awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0]        awaddr = 0, araddr = 0;
   logic [31:0]       wdata = 0, rdata, d;
   logic [1:0]        bresp, rresp, r;
   logic [11:0]       fcode = 0;
   logic [8:0]        din;
   logic [5:0]        dnorm, dout;
   pio_key_s          keys;
   pio_disp_s         disp;
   pio_motor_s        mot;
   int                fails = 0, total_checks = 0;
   localparam pio_key_s K_SET = 4'h8, K_UP = 4'h4, K_DN = 4'h2, K_MODE = 4'h1;
   initial forever #50 clk_in = ~clk_in;
   pio_far u_far (.clk_in(clk_in), .keys_out(keys), .input_line_out(din),
      .output_normal_out(dnorm));
   pio_panel u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .keys_in(keys), .display_out(disp), .servo_on_in(servo),
      .fault_valid_in(fvalid), .fault_code_in(fcode), .motor_out(mot), .input_line_in(din),
      .output_normal_in(dnorm), .output_line_out(dout), .irq_out(irq));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Both channels offered together; each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      @(posedge clk_in);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_in);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) begin r = bresp; bready <= 0; break; end
      end
      if (n == 50) begin fails++; wrap_up(); end
      `CHK(r, er)
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge clk_in);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_in);
         if (arready) arvalid <= 0;
         if (rvalid) begin d = rdata; r = rresp; rready <= 0; break; end
      end
      if (n == 50) begin fails++; wrap_up(); end
   endtask
   task automatic jog(input pio_key_s k, input pio_motor_s e);
      u_far.keys_out <= k;
      tick(3);
      `CHK(mot, e)
      u_far.keys_out <= '0;
      tick(2);
      `CHK(mot.run, 1'b0)
   endtask
   initial begin
      tick(2);
      rst_n_in <= 1;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_in); fvalid <= 1; fcode <= 12'h0a1 + 12'(i);
      end
      @(posedge clk_in); fvalid <= 0;
      for (int s = 0; s < 3; s++) begin
         wr(PIO_CTRL_OFS, 32'(s * 8 + 1), PIO_RESP_OKAY);
         u_far.hold(K_SET, 1);
         `CHK(disp.value, 20'(12'h0a3 - 12'(s)))
         u_far.hold(K_MODE, 1);
      end
      wr(PIO_IRQ_MASK_OFS, 32'h1, PIO_RESP_OKAY);
      `CHK(irq, 1'b1)
      rd(PIO_IRQ_STAT_OFS);
      `CHK(d[0], 1'b1)
      tick(1);
      `CHK(irq, 1'b0)
      rd(8'h20);
      `CHK(r, PIO_RESP_SLVERR)
      wr(8'h24, 32'h1, PIO_RESP_SLVERR);
      $display("test history and bus done");
      rd(PIO_JOG_SPEED_OFS);
      `CHK(d, 32'h14)
      wr(PIO_CTRL_OFS, 32'h2, PIO_RESP_OKAY);
      u_far.hold(K_SET, 1);
      `CHK(disp.value, 20'h14)
      repeat (3) u_far.hold(K_UP, 1);
      u_far.hold(K_DN, 1);
      rd(PIO_JOG_SPEED_OFS);
      `CHK(d, 32'h16)
      `CHK(disp.value, 20'h16)
      u_far.hold(K_SET, 1);
      `CHK(disp.jog_text, 1'b1)
      servo <= 1;
      jog(K_UP, 18'h20016);
      jog(K_DN, 18'h30016);
      servo <= 0;
      jog(K_UP, 18'h16);
      u_far.hold(K_MODE, 1);
      $display("test jog done");
      u_far.lines(9'h0, 6'h2a);
      tick(2);
      `CHK(dout, 6'h2a)
      wr(PIO_FORCE_MASK_OFS, 32'h5, PIO_RESP_OKAY);
      wr(PIO_FORCE_CTRL_OFS, 32'h006, PIO_RESP_OKAY);
      tick(1);
      `CHK(dout, 6'h05)
      wr(PIO_FORCE_MASK_OFS, 32'h2, PIO_RESP_OKAY);
      tick(1);
      `CHK(dout, 6'h02)
      wr(PIO_CTRL_OFS, 32'h3, PIO_RESP_OKAY);
      u_far.hold(K_SET, 1);
      `CHK(disp.value, 20'h2)
      `CHK(disp.blank[4], 1'b1)
      u_far.hold(K_MODE, 1);
      wr(PIO_FORCE_CTRL_OFS, 32'h106, PIO_RESP_OKAY);
      tick(1);
      `CHK(dout, 6'h2a)
      $display("test force done");
      wr(PIO_CTRL_OFS, 32'h4, PIO_RESP_OKAY);
      u_far.hold(K_SET, 1);
      u_far.lines(9'h1a1, 6'h2a);
      tick(3);
      `CHK(disp.value, 20'h1a1)
      u_far.lines(9'h0ff, 6'h2a);
      tick(3);
      `CHK(disp.value, 20'h0ff)
      u_far.hold(K_MODE, 1);
      wr(PIO_CTRL_OFS, 32'h5, PIO_RESP_OKAY);
      u_far.hold(K_SET, 1);
      `CHK(disp.value, 20'h2a)
      u_far.lines(9'h0ff, 6'h3c);
      tick(4);
      `CHK(disp.value, 20'h3c)
      $display("test diagnosis done");
      wrap_up();
   end
endmodule // tb_top
